// ===== gfh_fault_handler.sv
// fault response logic of a three half-bridge gate driver
`timescale 1ns/100ps
`default_nettype none
module gfh_fault_handler #(
	parameter int RETRY_CYCLES = gfh_pkg::RETRY_CYC
) (
	input  wire logic                ref_clk,
	input  wire logic                rstn,
	input  wire logic                hw_variant,
	input  wire logic                ds_threshold_pin,
	input  wire gfh_pkg::gfh_cfg_t   cfg,
	input  wire logic                clear_faults_cmd,
	input  wire logic                enable_reset_pulse,
	input  wire logic [5:0]          gate_cmd,
	input  wire logic [5:0]          gate_level_ok,
	input  wire logic [5:0]          ds_over_cmp,
	input  wire logic [2:0]          sense_over_cmp,
	input  wire logic                thermal_warning_cmp,
	output logic      [5:0]          gate_enable,
	output logic                     fault_out_n,
	output gfh_pkg::gfh_flags_t      flags,
	output logic      [3:0]          ds_threshold_code,
	output logic      [1:0]          sense_threshold_code
);
	import gfh_pkg::*;

	// ************************************************************
	// helpers
	// ************************************************************

	// shutdown scope of a gate fault in one phase
	function automatic logic [1:0] gdf_scope(input logic [2:0] mode, input logic mixed,
			input logic is_fet);
		if (mixed) begin
			return is_fet ? SCOPE_FET : SCOPE_HALF;
		end
		if (mode == PWM_HALF) begin
			return SCOPE_HALF;
		end
		if (mode[2]) begin
			return SCOPE_FET;
		end
		return SCOPE_ALL;
	endfunction

	// ************************************************************
	// input synchronisers
	// ************************************************************
	localparam int SW = 25;
	logic [SW-1:0] sync1;
	logic [SW-1:0] sync2;
	logic          rst_pin_prev;

	// two stages for every pin from the analogue side, comparators included
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {hw_variant, ds_threshold_pin, enable_reset_pulse, gate_cmd,
				gate_level_ok, thermal_warning_cmp, ds_over_cmp, sense_over_cmp};
			sync2 <= sync1;
		end
	end

	logic       hw;
	logic       pin_high;
	logic       rst_pin;
	logic [5:0] cmd_s;
	logic [5:0] ok_s;
	logic       otw_s;
	logic [5:0] ds_s;
	logic [2:0] sen_s;
	assign hw       = sync2[24];
	assign pin_high = sync2[23];
	assign rst_pin  = sync2[22];
	assign cmd_s    = sync2[21:16];
	assign ok_s     = sync2[15:10];
	assign otw_s    = sync2[9];
	assign ds_s     = sync2[8:3];
	assign sen_s    = sync2[2:0];

	// enable reset pulse seen as a rising edge of the synchronised pin
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rst_pin_prev <= 1'b0;
		end else begin
			rst_pin_prev <= rst_pin;
		end
	end

	logic clr;
	assign clr = clear_faults_cmd || (rst_pin && !rst_pin_prev);

	// ************************************************************
	// effective configuration
	// ************************************************************
	logic [1:0]       eff_mode;
	logic [CNT_W-1:0] deg_limit;
	logic             ds_mon_on;
	logic             sen_mon_on;
	logic [2:0]       ds_bridge_on;
	logic [2:0]       sen_bridge_on;
	logic             gdf_check_on;
	logic             otw_on;

	always_comb begin
		eff_mode = hw ? OCP_LATCH : cfg.overcurrent_response_mode;
		case (cfg.overcurrent_deglitch_sel)
			2'h0: deg_limit = DEG0_CYC;
			2'h1: deg_limit = DEG1_CYC;
			2'h2: deg_limit = DEG2_CYC;
			default: deg_limit = DEG3_CYC;
		endcase
		if (hw) begin
			deg_limit = HW_DEG_CYC;
		end
		ds_mon_on  = hw ? !pin_high : (eff_mode != OCP_OFF);
		sen_mon_on = hw ? !pin_high : (eff_mode != OCP_OFF);
		// per-bridge disables are locked out in the hardware variant
		ds_bridge_on  = hw ? 3'h7 : ~cfg.per_bridge_ds_monitor_off;
		sen_bridge_on = hw ? 3'h7 : ~cfg.per_bridge_sense_monitor_off;
		gdf_check_on  = hw || !cfg.gate_fault_check_off;
		otw_on        = !hw;
	end

	// threshold codes to the comparators, hardware variant fixed
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ds_threshold_code    <= '0;
			sense_threshold_code <= '0;
		end else begin
			ds_threshold_code    <= hw ? 4'h0 : cfg.drain_source_threshold_sel;
			sense_threshold_code <= hw ? 2'h0 : cfg.sense_threshold_sel;
		end
	end

	// ************************************************************
	// detection
	// ************************************************************
	logic [5:0] ds_level;
	logic [2:0] sen_level;
	logic [5:0] ds_evt;
	logic [2:0] sen_evt;
	logic [5:0] stuck_evt;

	// only transistors commanded on are watched
	assign ds_level  = ds_mon_on ? (ds_s & cmd_s & {2{ds_bridge_on}}) : 6'h00;
	assign sen_level = sen_mon_on ? (sen_s & sen_bridge_on) : 3'h0;

	gfh_deglitch #(.N(6)) u_ds_deg (
		.ref_clk     (ref_clk),
		.rstn        (rstn),
		.level       (ds_level),
		.limit       (deg_limit),
		.event_pulse (ds_evt)
	);

	gfh_deglitch #(.N(3)) u_sen_deg (
		.ref_clk     (ref_clk),
		.rstn        (rstn),
		.level       (sen_level),
		.limit       (deg_limit),
		.event_pulse (sen_evt)
	);

	gfh_gate_watch u_gate (
		.ref_clk     (ref_clk),
		.rstn        (rstn),
		.gate_cmd    (cmd_s),
		.gate_ok     (ok_s),
		.stuck_pulse (stuck_evt)
	);

	// ************************************************************
	// retry timer
	// ************************************************************
	logic [RETRY_W-1:0] retry_cnt;
	logic               retry_run;
	logic               retry_done;
	logic               oc_evt;
	assign oc_evt     = (|ds_evt) || (|sen_evt);
	assign retry_done = retry_run && (retry_cnt == RETRY_W'(RETRY_CYCLES - 1));

	// a new event restarts the interval
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			retry_run <= 1'b0;
			retry_cnt <= '0;
		end else if (oc_evt && eff_mode == OCP_RETRY) begin
			retry_run <= 1'b1;
			retry_cnt <= '0;
		end else if (retry_done || eff_mode != OCP_RETRY) begin
			retry_run <= 1'b0;
			retry_cnt <= '0;
		end else if (retry_run) begin
			retry_cnt <= retry_cnt + 1'b1;
		end
	end

	// ************************************************************
	// latched overcurrent flags
	// ************************************************************
	logic       oc_release;
	logic       ds_gone;
	logic       sen_gone;
	logic       ds_flag;
	logic [5:0] ds_fet_bits;
	logic       sen_flag;
	logic [2:0] sen_ch_bits;
	logic [5:0] vgs_bits;
	logic       otw_flag;
	logic       fault_flag;
	assign ds_gone  = !(|(ds_s & cmd_s));
	assign sen_gone = !(|sen_s);
	// retry mode frees on expiry, other modes on clear with the condition gone
	assign oc_release = (eff_mode == OCP_RETRY) ? retry_done : clr;

	// set wins over clear in the same cycle
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ds_flag     <= 1'b0;
			ds_fet_bits <= '0;
		end else if (|ds_evt) begin
			ds_flag     <= 1'b1;
			ds_fet_bits <= ds_fet_bits | ds_evt;
		end else if (oc_release && (eff_mode == OCP_RETRY || ds_gone)) begin
			ds_flag     <= 1'b0;
			ds_fet_bits <= '0;
		end
	end

	// sense flags, per-channel detail kept in retry mode only
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sen_flag    <= 1'b0;
			sen_ch_bits <= '0;
		end else if (|sen_evt) begin
			sen_flag <= 1'b1;
			if (eff_mode == OCP_RETRY) begin
				sen_ch_bits <= sen_ch_bits | sen_evt;
			end
		end else if (oc_release && (eff_mode == OCP_RETRY || sen_gone)) begin
			sen_flag    <= 1'b0;
			sen_ch_bits <= '0;
		end
	end

	// ************************************************************
	// gate drive fault flags
	// ************************************************************
	logic [5:0] gdf_lat;

	// per-transistor latch; gate voltage flag kept even with the check off
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			gdf_lat  <= '0;
			vgs_bits <= '0;
		end else begin
			for (int i = 0; i < 6; i++) begin
				if (stuck_evt[i]) begin
					vgs_bits[i] <= 1'b1;
					gdf_lat[i]  <= gdf_check_on;
				end else if (clr && ok_s[i]) begin
					vgs_bits[i] <= 1'b0;
					gdf_lat[i]  <= 1'b0;
				end
			end
		end
	end

	// the flag word has one driver; gate fault summary is the or of the latches
	assign flags = {fault_flag, ds_flag, ds_fet_bits, sen_flag, sen_ch_bits, |gdf_lat,
		vgs_bits, otw_flag};

	// ************************************************************
	// thermal warning and global flag
	// ************************************************************
	logic oc_report;
	logic report_any;
	assign oc_report  = flags.drain_source_overcurrent || flags.sense_overcurrent;
	assign report_any = oc_report || (|gdf_lat)
		|| (flags.thermal_warning && cfg.thermal_warning_to_pin);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			otw_flag   <= 1'b0;
			fault_flag <= 1'b0;
		end else begin
			otw_flag   <= otw_on && otw_s;
			fault_flag <= oc_report || (|gdf_lat);
		end
	end

	// ************************************************************
	// gate enables and fault pin
	// ************************************************************
	logic       oc_shut;
	logic [5:0] kill;
	assign oc_shut = oc_report && (eff_mode == OCP_LATCH || eff_mode == OCP_RETRY);

	// per-phase scope of gate fault shutdown
	always_comb begin
		kill = oc_shut ? 6'h3f : 6'h00;
		for (int p = 0; p < 3; p++) begin
			case (gdf_scope(cfg.pwm_mode, cfg.mixed_phase_en, cfg.phase_is_fet[p]))
				SCOPE_HALF: begin
					if (gdf_lat[p] || gdf_lat[p+3]) begin
						kill[p]   = 1'b1;
						kill[p+3] = 1'b1;
					end
				end
				SCOPE_FET: begin
					kill[p]   = kill[p] | gdf_lat[p];
					kill[p+3] = kill[p+3] | gdf_lat[p+3];
				end
				default: begin
					if (|gdf_lat) begin
						kill = 6'h3f;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			gate_enable <= GATE_EN_RST;
			fault_out_n <= FAULT_N_RST;
		end else begin
			gate_enable <= ~kill;
			fault_out_n <= !report_any;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	latched_hold_a: assert property (flags.drain_source_overcurrent && eff_mode == OCP_LATCH
		&& !clr |=> flags.drain_source_overcurrent) else $error("latched flag dropped");
	oc_shutdown_a: assert property (oc_report && eff_mode == OCP_LATCH
		|=> gate_enable == 6'h00) else $error("gates not off on overcurrent");
	retry_free_a: assert property (retry_done && !oc_evt && eff_mode == OCP_RETRY
		|=> !flags.drain_source_overcurrent ##1 (fault_out_n || report_any))
		else $error("retry did not recover");
	report_only_a: assert property (eff_mode == OCP_REPORT && gdf_lat == 6'h00
		|=> gate_enable == 6'h3f) else $error("report mode stopped drivers");
	mode_off_a: assert property (!hw && eff_mode == OCP_OFF
		|-> ##2 ds_evt == 6'h00) else $error("disabled monitor fired");
	hw_fixed_a: assert property (hw |-> eff_mode == OCP_LATCH && deg_limit == HW_DEG_CYC)
		else $error("hardware variant not fixed");
	pin_follow_a: assert property (flags.drain_source_overcurrent || flags.sense_overcurrent
		|| flags.gate_drive_fault |=> !fault_out_n) else $error("fault pin not asserted");
	otw_pin_a: assert property (!hw && cfg.thermal_warning_to_pin && flags.thermal_warning
		|=> !fault_out_n) else $error("thermal warning not on pin");
	gdf_all_a: assert property (|gdf_lat && !cfg.mixed_phase_en && !cfg.pwm_mode[2]
		&& cfg.pwm_mode != PWM_HALF |=> gate_enable == 6'h00)
		else $error("gate fault left drivers on");
	vgs_keep_a: assert property ($rose(flags.gate_voltage_fault_flag[0]) && !gdf_check_on
		|-> !gdf_lat[0]) else $error("disabled check latched fault");

	retry_seen_c: cover property (retry_done);
	gdf_seen_c:   cover property ($rose(flags.gate_drive_fault));
	sense_seen_c: cover property ($rose(flags.sense_overcurrent) ##[1:20] clr);

endmodule
`default_nettype wire

// ===== gfh_pkg.sv
// shared constants and carrier types of the gate driver fault handler
package gfh_pkg;

	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int CLK_MHZ       = 100;                   // ref_clk rate
	localparam int HW_DEG_US     = 4;                     // fixed deglitch, hardware variant
	localparam int DEG0_US       = 1;                     // deglitch choices, serial variant
	localparam int DEG1_US       = 2;
	localparam int DEG2_US       = 4;
	localparam int DEG3_US       = 8;
	localparam int DRIVE_US      = 4;                     // gate drive window
	localparam int RETRY_US      = 4000;                  // automatic retry interval
	localparam int CNT_W         = 10;
	localparam logic [CNT_W-1:0] HW_DEG_CYC = CNT_W'(HW_DEG_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] DEG0_CYC   = CNT_W'(DEG0_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] DEG1_CYC   = CNT_W'(DEG1_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] DEG2_CYC   = CNT_W'(DEG2_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] DEG3_CYC   = CNT_W'(DEG3_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] DRIVE_CYC  = CNT_W'(DRIVE_US * CLK_MHZ);
	localparam int RETRY_CYC     = RETRY_US * CLK_MHZ;    // above 4096: top parameter default
	localparam int RETRY_W       = 20;

	// ************************************************************
	// overcurrent response modes and pwm modes
	// ************************************************************
	localparam logic [1:0] OCP_LATCH  = 2'h0;
	localparam logic [1:0] OCP_RETRY  = 2'h1;
	localparam logic [1:0] OCP_REPORT = 2'h2;
	localparam logic [1:0] OCP_OFF    = 2'h3;
	localparam logic [2:0] PWM_HALF   = 3'h3;             // independent half-bridge
	localparam logic [1:0] SCOPE_ALL  = 2'h0;
	localparam logic [1:0] SCOPE_HALF = 2'h1;
	localparam logic [1:0] SCOPE_FET  = 2'h2;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [5:0] GATE_EN_RST = 6'h00;
	localparam logic       FAULT_N_RST = 1'b1;

	// configuration from the host controller
	typedef struct packed {
		logic [1:0] overcurrent_response_mode;
		logic [1:0] overcurrent_deglitch_sel;
		logic [3:0] drain_source_threshold_sel;
		logic [1:0] sense_threshold_sel;
		logic [2:0] per_bridge_ds_monitor_off;
		logic [2:0] per_bridge_sense_monitor_off;
		logic       gate_fault_check_off;
		logic       thermal_warning_to_pin;
		logic [2:0] pwm_mode;
		logic       mixed_phase_en;
		logic [2:0] phase_is_fet;
	} gfh_cfg_t;

	// flags shown to the host, latched except the thermal warning
	typedef struct packed {
		logic       fault;
		logic       drain_source_overcurrent;
		logic [5:0] ds_fet;
		logic       sense_overcurrent;
		logic [2:0] sense_ch;
		logic       gate_drive_fault;
		logic [5:0] gate_voltage_fault_flag;
		logic       thermal_warning;
	} gfh_flags_t;

endpackage

// ===== gfh_deglitch.sv
// per-lane deglitch filter, one pulse once a lane stays high past the limit
`timescale 1ns/100ps
`default_nettype none
module gfh_deglitch #(
	parameter int N = 6
) (
	input  wire logic                         ref_clk,
	input  wire logic                         rstn,
	input  wire logic [N-1:0]                 level,
	input  wire logic [gfh_pkg::CNT_W-1:0]    limit,
	output logic      [N-1:0]                 event_pulse
);
	import gfh_pkg::*;

	logic [CNT_W-1:0] cnt [N];

	// count while high, restart when low, saturate after firing
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < N; i++) begin
				cnt[i] <= '0;
			end
			event_pulse <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				event_pulse[i] <= level[i] && (cnt[i] == limit);
				if (!level[i]) begin
					cnt[i] <= '0;
				end else if (cnt[i] <= limit) begin
					cnt[i] <= cnt[i] + 1'b1;
				end
			end
		end
	end

endmodule
`default_nettype wire

// ===== gfh_gate_watch.sv
// per-transistor gate drive window check
`timescale 1ns/100ps
`default_nettype none
module gfh_gate_watch (
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic [5:0] gate_cmd,
	input  wire logic [5:0] gate_ok,
	output logic      [5:0] stuck_pulse
);
	import gfh_pkg::*;

	logic [5:0]       prev_cmd;
	logic [5:0]       busy;
	logic [CNT_W-1:0] cnt [6];

	// window opens on each command edge, verdict at its end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			prev_cmd    <= '0;
			busy        <= '0;
			stuck_pulse <= '0;
			for (int i = 0; i < 6; i++) begin
				cnt[i] <= '0;
			end
		end else begin
			prev_cmd <= gate_cmd;
			for (int i = 0; i < 6; i++) begin
				stuck_pulse[i] <= busy[i] && (cnt[i] == DRIVE_CYC) && !gate_ok[i];
				if (gate_cmd[i] != prev_cmd[i]) begin
					busy[i] <= 1'b1;
					cnt[i]  <= '0;
				end else if (busy[i] && cnt[i] == DRIVE_CYC) begin
					busy[i] <= 1'b0;
				end else if (busy[i]) begin
					cnt[i] <= cnt[i] + 1'b1;
				end
			end
		end
	end

endmodule
`default_nettype wire

// ===== gfh_host_model.sv
// host controller model issuing fault clears and enable reset pulses
`timescale 1ns/100ps
`default_nettype none
module gfh_host_model (
	input  wire logic ref_clk,
	input  wire logic do_clear,
	input  wire logic do_pulse,
	output logic      clear_faults_cmd,
	output logic      enable_reset_pulse
);
	// ************************************************************
	// requests reach the pins at the falling edge, one cycle wide
	// ************************************************************
	always @(negedge ref_clk) begin
		clear_faults_cmd   <= do_clear;
		enable_reset_pulse <= do_pulse;
	end
endmodule
`default_nettype wire

// ===== gfh_fault_handler_test.sv
// self-checking bench of the fault handler
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
	$display("wrong value %s expected %h seen %h", n, e, g); end end
module gfh_fault_handler_test;
	import gfh_pkg::*;
	logic       ref_clk = 1'b0;
	logic       rstn = 1'b0;
	logic       do_clear = 1'b0;
	logic       do_pulse = 1'b0;
	logic       clr_cmd;
	logic       en_pulse;
	logic       fault_out_n;
	logic       therm = 1'b0;
	logic [5:0] gate_cmd = 6'h3f;
	logic [5:0] gate_ok = 6'h3f;
	logic [5:0] ds_cmp = 6'h00;
	logic [5:0] gate_enable;
	logic [2:0] sen_cmp = 3'h0;
	logic [3:0] ds_code;
	logic [1:0] sen_code;
	logic       hw_var = 1'b0;
	logic       thr_pin = 1'b0;
	gfh_cfg_t   cfg = '0;
	gfh_flags_t flags;
	int         checks = 0;
	int         mismatches = 0;

	// ************************************************************
	// clock, host model and design
	// ************************************************************
	always #5 ref_clk = ~ref_clk;
	gfh_host_model u_host (.ref_clk(ref_clk), .do_clear(do_clear), .do_pulse(do_pulse),
		.clear_faults_cmd(clr_cmd), .enable_reset_pulse(en_pulse));
	gfh_fault_handler #(.RETRY_CYCLES(50)) u_dut (.ref_clk(ref_clk), .rstn(rstn),
		.hw_variant(hw_var), .ds_threshold_pin(thr_pin), .cfg(cfg), .clear_faults_cmd(clr_cmd),
		.enable_reset_pulse(en_pulse), .gate_cmd(gate_cmd), .gate_level_ok(gate_ok),
		.ds_over_cmp(ds_cmp), .sense_over_cmp(sen_cmp), .thermal_warning_cmp(therm),
		.gate_enable(gate_enable), .fault_out_n(fault_out_n), .flags(flags),
		.ds_threshold_code(ds_code), .sense_threshold_code(sen_code));

	// ************************************************************
	// shared tasks
	// ************************************************************
	task give_verdict;
		if (mismatches == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task run(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// one clear request through the host, by command or enable pulse
	task clr(input logic pin);
		@(posedge ref_clk);
		if (pin) do_pulse <= 1'b1;
		else do_clear <= 1'b1;
		@(posedge ref_clk);
		do_pulse <= 1'b0;
		do_clear <= 1'b0;
		run(8);
	endtask
	// drain-source overcurrent on transistor 0 in one response mode
	task ds(input logic [1:0] m, input logic [5:0] ge, input logic fn);
		cfg.overcurrent_response_mode = m;
		ds_cmp = 6'h01;
		run(120);
		`CHK("ds gate_enable", ge, gate_enable)
		`CHK("ds fault_out_n", fn, fault_out_n)
		`CHK("ds flag", {6{m != 2'h3}} & 6'h01, flags.ds_fet)
		`CHK("ds fault flag", m != 2'h3, flags.fault)
		ds_cmp = 6'h00;
		run(4);
		if (m == OCP_RETRY) run(100);
		else clr(1'b0);
		`CHK("ds recovered", 8'hbf, {fault_out_n, flags.drain_source_overcurrent, gate_enable})
	endtask
	// gate stuck on transistor 0 under one shutdown scope
	task gf(input logic [2:0] p, input logic off, input logic x, input logic [5:0] e);
		cfg.pwm_mode = p;
		cfg.gate_fault_check_off = off;
		cfg.mixed_phase_en = x;
		cfg.phase_is_fet = 3'h1;
		gate_ok = 6'h3e;
		gate_cmd = 6'h3e;
		run(420);
		`CHK("gate scope", e, gate_enable)
		`CHK("gate flag", 6'h01, flags.gate_voltage_fault_flag)
		`CHK("gate pin", off, fault_out_n)
		gate_ok = 6'h3f;
		gate_cmd = 6'h3f;
		run(5);
		clr(1'b0);
		`CHK("gate cleared", 7'h3f, {flags.gate_drive_fault, gate_enable})
	endtask
	// sense overcurrent on phase 1 in one response mode
	task sn(input logic [1:0] m, input logic [5:0] ge);
		cfg.overcurrent_response_mode = m;
		sen_cmp = 3'h2;
		run(120);
		`CHK("sn gate_enable", ge, gate_enable)
		`CHK("sn pin", 1'b0, fault_out_n)
		`CHK("sense ch", {3{m == OCP_RETRY}} & 3'h2, flags.sense_ch)
		sen_cmp = 3'h0;
		run(4);
		if (m == OCP_RETRY) run(100);
		else clr(1'b1);
		`CHK("sn recovered", 8'hbf, {fault_out_n, flags.sense_overcurrent, gate_enable})
	endtask

	// ************************************************************
	// main sequence and watchdog
	// ************************************************************
	initial begin
		cfg.drain_source_threshold_sel = 4'h5;
		cfg.sense_threshold_sel = 2'h2;
		run(12);
		rstn = 1'b1;
		run(6);
		`CHK("idle", 7'h7f, {fault_out_n, gate_enable})
		`CHK("ds code", 4'h5, ds_code)
		`CHK("sense code", 2'h2, sen_code)
		ds_cmp = 6'h01;
		run(50);
		ds_cmp = 6'h00;
		run(60);
		`CHK("short glitch", 1'b1, fault_out_n)
		ds(OCP_LATCH, 6'h00, 1'b0);
		ds(OCP_RETRY, 6'h00, 1'b0);
		ds(OCP_REPORT, 6'h3f, 1'b0);
		ds(OCP_OFF, 6'h3f, 1'b1);
		cfg.overcurrent_response_mode = OCP_LATCH;
		sen_cmp = 3'h2;
		run(120);
		`CHK("sense trip", 7'h40, {flags.sense_overcurrent, gate_enable})
		clr(1'b0);
		`CHK("sense held", 1'b1, flags.sense_overcurrent)
		sen_cmp = 3'h0;
		run(4);
		clr(1'b1);
		`CHK("sense cleared", 8'hbf, {fault_out_n, flags.sense_overcurrent, gate_enable})
		sn(OCP_RETRY, 6'h00);
		sn(OCP_REPORT, 6'h3f);
		cfg.overcurrent_response_mode = OCP_LATCH;
		gf(3'h0, 1'b0, 1'b0, 6'h00);
		gf(PWM_HALF, 1'b0, 1'b0, 6'h36);
		gf(3'h7, 1'b0, 1'b0, 6'h3e);
		gf(3'h0, 1'b0, 1'b1, 6'h3e);
		gf(3'h0, 1'b1, 1'b0, 6'h3f);
		therm = 1'b1;
		run(6);
		`CHK("warn quiet", 2'h3, {flags.thermal_warning, fault_out_n})
		cfg.thermal_warning_to_pin = 1'b1;
		run(3);
		`CHK("warn pin", 1'b0, fault_out_n)
		therm = 1'b0;
		run(6);
		`CHK("warn gone", 2'h1, {flags.thermal_warning, fault_out_n})
		// hardware variant: fixed latched response, no warning, pin disables monitors
		hw_var = 1'b1;
		run(4);
		cfg.overcurrent_response_mode = OCP_REPORT;
		`CHK("hw codes", 6'h00, {ds_code, sen_code})
		ds_cmp = 6'h01;
		therm = 1'b1;
		run(420);
		`CHK("hw ds latch", 7'h00, {fault_out_n, gate_enable})
		`CHK("hw no warn", 1'b0, flags.thermal_warning)
		ds_cmp = 6'h00;
		therm = 1'b0;
		run(4);
		clr(1'b0);
		`CHK("hw recovered", 7'h7f, {fault_out_n, gate_enable})
		thr_pin = 1'b1;
		ds_cmp = 6'h01;
		sen_cmp = 3'h4;
		run(420);
		`CHK("hw pin off", 8'hbf, {fault_out_n, flags.fault, gate_enable})
		give_verdict();
	end
	initial begin
		#80000;
		mismatches++;
		give_verdict();
	end
endmodule
`default_nettype wire
